// >>> inc/sfie_pkg.sv
// Package with opcodes, flag positions and the status reset value for the status flag instruction executor.
package sfie_pkg;

  localparam int unsigned op_width = 16;
  localparam int unsigned status_width = 8;

  // Opcode words of the single-word instructions handled here.
  localparam logic [15:0] op_nop = 16'h0000;
  localparam logic [15:0] set_sign_flag_op = 16'h9448;
  localparam logic [15:0] clear_sign_flag_op = 16'h94c8;
  localparam logic [15:0] set_overflow_flag_op = 16'h9438;
  localparam logic [15:0] clear_overflow_flag_op = 16'h94b8;
  localparam logic [15:0] set_transfer_bit_op = 16'h9468;
  localparam logic [15:0] clear_transfer_bit_op = 16'h94e8;
  localparam logic [15:0] op_sleep = 16'h9588;
  localparam logic [15:0] watchdog_restart_op = 16'h95a8;

  // Bit positions inside the core status register.
  localparam int unsigned bit_overflow = 3;
  localparam int unsigned bit_sign = 4;
  localparam int unsigned bit_transfer = 6;

  localparam logic [7:0] status_reset = 8'h00;

  typedef enum logic [3:0] {
    sfie_nop_k = 4'h0,
    sfie_sign_set_k = 4'h1,
    sfie_sign_clear_k = 4'h2,
    sfie_ovf_set_k = 4'h3,
    sfie_ovf_clear_k = 4'h4,
    sfie_tbit_set_k = 4'h5,
    sfie_tbit_clear_k = 4'h6,
    sfie_sleep_k = 4'h7,
    sfie_restart_k = 4'h8,
    sfie_other_k = 4'h9
  } sfie_cmd_t;

endpackage : sfie_pkg

// >>> core/sfie_decode.sv
// Opcode decoder that maps an instruction word to an executor command.
`timescale 1ns/1ps
`default_nettype none
module sfie_decode (
  input wire logic [15:0] opcode,
  output sfie_pkg::sfie_cmd_t cmd
);

  always_comb
  begin
    case (opcode)
      sfie_pkg::op_nop: cmd = sfie_pkg::sfie_nop_k;
      sfie_pkg::set_sign_flag_op: cmd = sfie_pkg::sfie_sign_set_k;
      sfie_pkg::clear_sign_flag_op: cmd = sfie_pkg::sfie_sign_clear_k;
      sfie_pkg::set_overflow_flag_op: cmd = sfie_pkg::sfie_ovf_set_k;
      sfie_pkg::clear_overflow_flag_op: cmd = sfie_pkg::sfie_ovf_clear_k;
      sfie_pkg::set_transfer_bit_op: cmd = sfie_pkg::sfie_tbit_set_k;
      sfie_pkg::clear_transfer_bit_op: cmd = sfie_pkg::sfie_tbit_clear_k;
      sfie_pkg::op_sleep: cmd = sfie_pkg::sfie_sleep_k;
      sfie_pkg::watchdog_restart_op: cmd = sfie_pkg::sfie_restart_k;
      default: cmd = sfie_pkg::sfie_other_k;
    endcase
  end

endmodule : sfie_decode
`default_nettype wire

// >>> core/sfie_exec.sv
// Executor for status flag, sleep, watchdog restart and no-operation instructions.
`timescale 1ns/1ps
`default_nettype none
module sfie_exec (
  input wire logic clock,
  input wire logic reset,
  input wire logic issue_valid,
  input wire logic [15:0] issue_opcode,
  input wire logic status_load,
  input wire logic [7:0] status_load_value,
  output logic [7:0] core_status_register,
  output logic sleep_request,
  output logic watchdog_restart,
  output logic issue_done,
  output logic issue_unknown
);

  // All state of the executor, registered as one word.
  typedef struct packed {
    logic [7:0] status;
    logic sleep;
    logic restart;
    logic done;
    logic unknown;
  } sfie_state_t;

  sfie_state_t state_q;
  sfie_state_t state_d;
  sfie_pkg::sfie_cmd_t cmd;

  // Builds a one-hot mask for a status bit position.
  function automatic logic [7:0] flag_mask(input int unsigned pos);
    return 8'h01 << pos;
  endfunction : flag_mask

  ////////////////////////////////////////////////////////////////////////////////
  // Opcode decoding.

  sfie_decode u_decode (
    .opcode(issue_opcode),
    .cmd(cmd)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb
  begin
    state_d = state_q;
    state_d.sleep = 1'b0;
    state_d.restart = 1'b0;
    state_d.done = issue_valid;
    state_d.unknown = 1'b0;
    // A load from the other write path applies first, so a flag instruction in the same cycle wins its bit.
    if (status_load)
    begin
      state_d.status = status_load_value;
    end
    if (issue_valid)
    begin
      case (cmd)
        sfie_pkg::sfie_sign_set_k: state_d.status[sfie_pkg::bit_sign] = 1'b1;
        sfie_pkg::sfie_sign_clear_k: state_d.status[sfie_pkg::bit_sign] = 1'b0;
        sfie_pkg::sfie_ovf_set_k: state_d.status[sfie_pkg::bit_overflow] = 1'b1;
        sfie_pkg::sfie_ovf_clear_k: state_d.status[sfie_pkg::bit_overflow] = 1'b0;
        sfie_pkg::sfie_tbit_set_k: state_d.status[sfie_pkg::bit_transfer] = 1'b1;
        sfie_pkg::sfie_tbit_clear_k: state_d.status[sfie_pkg::bit_transfer] = 1'b0;
        sfie_pkg::sfie_sleep_k: state_d.sleep = 1'b1;
        sfie_pkg::sfie_restart_k: state_d.restart = 1'b1;
        sfie_pkg::sfie_nop_k: state_d.unknown = 1'b0;
        default: state_d.unknown = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_q <= '{status: sfie_pkg::status_reset, sleep: 1'b0, restart: 1'b0, done: 1'b0, unknown: 1'b0};
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs, each taken straight from the state register.

  assign core_status_register = state_q.status;
  assign sleep_request = state_q.sleep;
  assign watchdog_restart = state_q.restart;
  assign issue_done = state_q.done;
  assign issue_unknown = state_q.unknown;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  localparam logic [7:0] mask_s = flag_mask(sfie_pkg::bit_sign);
  localparam logic [7:0] mask_v = flag_mask(sfie_pkg::bit_overflow);
  localparam logic [7:0] mask_t = flag_mask(sfie_pkg::bit_transfer);

  // An instruction issued with no load from the other write path.
  sequence issue_of(sfie_pkg::sfie_cmd_t c);
    issue_valid && !status_load && cmd == c;
  endsequence

  // An instruction issued in the same cycle as a load.
  sequence load_with(sfie_pkg::sfie_cmd_t c);
    issue_valid && status_load && cmd == c;
  endsequence

  // A cycle with neither an issue nor a load.
  sequence idle_cycle;
    !issue_valid && !status_load;
  endsequence

  sign_set_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_sign_set_k) |=> core_status_register == ($past(core_status_register) | mask_s))
    else $error("Set-sign did not set only the sign bit.");

  sign_clear_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_sign_clear_k) |=> core_status_register == ($past(core_status_register) & ~mask_s))
    else $error("Clear-sign did not clear only the sign bit.");

  ovf_set_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_ovf_set_k) |=> core_status_register == ($past(core_status_register) | mask_v))
    else $error("Set-overflow did not set only the overflow bit.");

  ovf_clear_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_ovf_clear_k) |=> core_status_register == ($past(core_status_register) & ~mask_v))
    else $error("Clear-overflow did not clear only the overflow bit.");

  sleep_pulse_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_sleep_k) |=> sleep_request && $stable(core_status_register))
    else $error("Sleep did not pulse or altered flags.");

  restart_pulse_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_restart_k) |=> watchdog_restart && $stable(core_status_register))
    else $error("Watchdog restart did not pulse or altered flags.");

  transfer_set_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_tbit_set_k) |=> core_status_register == ($past(core_status_register) | mask_t))
    else $error("Transfer set did not set only the transfer bit.");

  transfer_clear_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_tbit_clear_k) |=> core_status_register == ($past(core_status_register) & ~mask_t))
    else $error("Transfer clear did not clear only the transfer bit.");

  nop_quiet_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_nop_k) |=> $stable(core_status_register) && !sleep_request && !watchdog_restart
      && !issue_unknown && issue_done)
    else $error("No-operation changed state.");

  pulse_single_a: assert property (@(posedge clock) disable iff (reset)
    sleep_request |=> !sleep_request || $past(issue_valid))
    else $error("Sleep request held without a new issue.");

  restart_single_a: assert property (@(posedge clock) disable iff (reset)
    watchdog_restart |=> !watchdog_restart || $past(issue_valid))
    else $error("Watchdog restart held without a new issue.");

  sleep_alone_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_sleep_k) |=> !watchdog_restart && !issue_unknown && issue_done)
    else $error("Sleep raised another pulse.");

  restart_alone_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_restart_k) |=> !sleep_request && !issue_unknown && issue_done)
    else $error("Watchdog restart raised another pulse.");

  pulse_exclusive_a: assert property (@(posedge clock) disable iff (reset)
    !(sleep_request && watchdog_restart))
    else $error("Sleep and watchdog restart pulsed together.");

  done_pulse_a: assert property (@(posedge clock) disable iff (reset)
    issue_valid |=> issue_done)
    else $error("Issue was not marked done one cycle later.");

  idle_quiet_a: assert property (@(posedge clock) disable iff (reset)
    idle_cycle |=> $stable(core_status_register) && !issue_done && !issue_unknown && !sleep_request
      && !watchdog_restart)
    else $error("State changed in an idle cycle.");

  unknown_pulse_a: assert property (@(posedge clock) disable iff (reset)
    issue_of(sfie_pkg::sfie_other_k) |=> issue_unknown && $stable(core_status_register))
    else $error("Unhandled opcode did not pulse or altered flags.");

  load_sign_set_a: assert property (@(posedge clock) disable iff (reset)
    load_with(sfie_pkg::sfie_sign_set_k) |=> core_status_register == ($past(status_load_value) | mask_s))
    else $error("Set-sign lost against a load.");

  load_sign_clear_a: assert property (@(posedge clock) disable iff (reset)
    load_with(sfie_pkg::sfie_sign_clear_k) |=> core_status_register == ($past(status_load_value) & ~mask_s))
    else $error("Clear-sign lost against a load.");

  load_ovf_set_a: assert property (@(posedge clock) disable iff (reset)
    load_with(sfie_pkg::sfie_ovf_set_k) |=> core_status_register == ($past(status_load_value) | mask_v))
    else $error("Set-overflow lost against a load.");

  load_ovf_clear_a: assert property (@(posedge clock) disable iff (reset)
    load_with(sfie_pkg::sfie_ovf_clear_k) |=> core_status_register == ($past(status_load_value) & ~mask_v))
    else $error("Clear-overflow lost against a load.");

  load_tbit_set_a: assert property (@(posedge clock) disable iff (reset)
    load_with(sfie_pkg::sfie_tbit_set_k) |=> core_status_register == ($past(status_load_value) | mask_t))
    else $error("Transfer set lost against a load.");

  load_tbit_clear_a: assert property (@(posedge clock) disable iff (reset)
    load_with(sfie_pkg::sfie_tbit_clear_k) |=> core_status_register == ($past(status_load_value) & ~mask_t))
    else $error("Transfer clear lost against a load.");

  load_plain_a: assert property (@(posedge clock) disable iff (reset)
    status_load && !issue_valid |=> core_status_register == $past(status_load_value))
    else $error("Load did not reach the status register.");

  reset_clear_a: assert property (@(posedge clock)
    reset |=> core_status_register == sfie_pkg::status_reset && !issue_done && !issue_unknown
      && !sleep_request && !watchdog_restart)
    else $error("Reset did not clear the executor state.");

endmodule : sfie_exec
`default_nettype wire

// >>> tb/sfie_exec_bench.sv
// Randomised self-checking bench for the status flag instruction executor.
`timescale 1ns/1ps
`default_nettype none
module sfie_exec_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic issue_valid = 1'b0;
  logic [15:0] issue_opcode = 16'h0000;
  logic status_load = 1'b0;
  logic [7:0] status_load_value = 8'h00;
  logic [7:0] core_status_register;
  logic sleep_request, watchdog_restart, issue_done, issue_unknown;
  logic [7:0] exp_status = 8'h00;
  logic [3:0] exp_pulse = 4'h0;
  logic [31:0] seed = 32'h062c;
  logic [15:0] ops [9];
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  sfie_exec u_sfie_exec (.clock(clock), .reset(reset), .issue_valid(issue_valid), .issue_opcode(issue_opcode),
    .status_load(status_load), .status_load_value(status_load_value), .core_status_register(core_status_register),
    .sleep_request(sleep_request), .watchdog_restart(watchdog_restart), .issue_done(issue_done),
    .issue_unknown(issue_unknown));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h expected=%h", $time, seen, want);
    end
  endtask : check
  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : complete_run
  // Drives one cycle, checks the previous one and predicts the next outputs.
  task automatic step(input logic rst, input logic v, input logic [15:0] op, input logic ld, input logic [7:0] lv);
    logic known;
    @(posedge clock);
    reset <= rst;
    issue_valid <= v;
    issue_opcode <= op;
    status_load <= ld;
    status_load_value <= lv;
    @(negedge clock);
    check(core_status_register, exp_status);
    check({4'h0, issue_done, issue_unknown, watchdog_restart, sleep_request}, {4'h0, exp_pulse});
    known = 1'b0;
    for (int i = 0; i < 9; i++)
      known |= (op === ops[i]);
    if (ld)
      exp_status = lv;
    if (v)
    begin
      case (op)
        sfie_pkg::set_sign_flag_op: exp_status[sfie_pkg::bit_sign] = 1'b1;
        sfie_pkg::clear_sign_flag_op: exp_status[sfie_pkg::bit_sign] = 1'b0;
        sfie_pkg::set_overflow_flag_op: exp_status[sfie_pkg::bit_overflow] = 1'b1;
        sfie_pkg::clear_overflow_flag_op: exp_status[sfie_pkg::bit_overflow] = 1'b0;
        sfie_pkg::set_transfer_bit_op: exp_status[sfie_pkg::bit_transfer] = 1'b1;
        sfie_pkg::clear_transfer_bit_op: exp_status[sfie_pkg::bit_transfer] = 1'b0;
        default: ;
      endcase
    end
    exp_pulse = {v, v & !known, v & (op == sfie_pkg::watchdog_restart_op), v & (op == sfie_pkg::op_sleep)};
    if (rst)
    begin
      exp_status = sfie_pkg::status_reset;
      exp_pulse = 4'h0;
    end
  endtask : step
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      complete_run();
    end
  end
  initial
  begin
    ops = '{sfie_pkg::op_nop, sfie_pkg::set_sign_flag_op, sfie_pkg::clear_sign_flag_op,
      sfie_pkg::set_overflow_flag_op, sfie_pkg::clear_overflow_flag_op, sfie_pkg::set_transfer_bit_op,
      sfie_pkg::clear_transfer_bit_op, sfie_pkg::op_sleep, sfie_pkg::watchdog_restart_op};
    repeat (20) step(1'b1, 1'b1, sfie_pkg::set_sign_flag_op, 1'b0, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      step(1'b0, 1'b0, 16'h0000, 1'b1, k ? 8'h00 : 8'hff);
      for (int i = 0; i < 9; i++)
        step(1'b0, 1'b1, ops[i], 1'b0, 8'h00);
    end
    step(1'b0, 1'b1, sfie_pkg::set_sign_flag_op, 1'b1, 8'h00);
    step(1'b0, 1'b1, sfie_pkg::clear_sign_flag_op, 1'b1, 8'hff);
    step(1'b0, 1'b1, 16'hffff, 1'b0, 8'h00);
    step(1'b1, 1'b1, sfie_pkg::set_overflow_flag_op, 1'b0, 8'h00);
    repeat (3000)
    begin
      seed = xorshift(seed);
      step(seed[31:24] == 8'h00, seed[4] | seed[5], (seed[3:0] < 4'h9) ? ops[seed[3:0]] : seed[31:16],
        seed[6] & seed[7], seed[15:8]);
    end
    step(1'b0, 1'b0, 16'h0000, 1'b0, 8'h00);
    complete_run();
  end
endmodule : sfie_exec_bench
`default_nettype wire
